// file: scc_pkg.sv
// package: register map, field positions, timing constants and carriers
package scc_pkg;

  // ***************************************************************
  // register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_BITRATE = 8'h04;
  localparam logic [7:0] OFF_CTRL    = 8'h08;
  localparam logic [7:0] OFF_TDATA   = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_RDATA   = 8'h14;
  localparam logic [7:0] OFF_CARD    = 8'h18;
  localparam logic [7:0] OFF_PORT    = 8'h1C;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int MODE_ODD_BIT    = 4;
  localparam int CTRL_TIE_BIT    = 7;
  localparam int CTRL_RIE_BIT    = 6;
  localparam int CTRL_TE_BIT     = 5;
  localparam int CTRL_RE_BIT     = 4;
  localparam int CTRL_CLOCK_SOURCE_SELECT_BIT   = 1;
  localparam int CTRL_CLOCK_OUTPUT_ENABLE_BIT   = 0;
  localparam int STAT_RECEIVE_FULL_FLAG_BIT   = 6;
  localparam int STAT_ERS_BIT    = 4;
  localparam int STAT_PER_BIT    = 3;
  localparam int STAT_TRANSMIT_END_FLAG_BIT   = 2;
  localparam int CARD_SMIF_BIT   = 0;
  localparam int PORT_DIR_BIT    = 3;
  localparam int PORT_DAT_BIT    = 2;
  localparam int PORT_SCKIN_BIT  = 1;
  localparam int PORT_RXIN_BIT   = 0;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_BITRATE = 8'hFF;
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_CARD    = 8'h00;
  localparam logic [7:0] RST_PORT    = 8'h00;

  // ***************************************************************
  // timing: base pulses per bit, sample pulse, frame layout
  // ***************************************************************
  localparam int         BASE_RATIO   = 372;
  localparam int         SAMPLE_PULSE = 186;
  localparam logic [8:0] CNT_LAST     = 9'(BASE_RATIO - 1);
  localparam logic [8:0] CNT_SAMPLE   = 9'(SAMPLE_PULSE - 1);
  localparam logic [3:0] FRAME_BITS   = 4'hA;
  localparam logic [3:0] BIT_PARITY   = 4'h9;
  localparam logic [3:0] BIT_SLOT_A   = 4'hA;
  localparam logic [3:0] BIT_SLOT_B   = 4'hB;
  localparam logic [3:0] BIT_GUARD    = 4'hC;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic o;
    logic oe;
  } scc_pin_t;

  typedef struct packed {
    logic receive_full_flag;
    logic ers;
    logic parity_error_flag;
    logic transmit_end_flag;
  } scc_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_FRAME, ST_TX_FRAME, ST_SLOT, ST_GUARD
  } scc_state_t;

endpackage

// file: scc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module scc_sync import scc_pkg::*; #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// file: scc_clkgen.sv
// base clock pulse and card clock generator with clean stop and start
`timescale 1ns/100ps
module scc_clkgen import scc_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] divider,
  input  wire logic       run_req,
  input  wire logic       idle_level,
  output logic            base_tick,
  output logic            sck_level
);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       phase_reg;
  logic       phase_next;
  logic       run_reg;
  logic       run_next;
  logic       tick_reg;
  logic       tick_next;
  logic       sck_reg;
  logic       sck_next;
  logic       half;

  // ***************************************************************
  // half period divider, card period = two halves = one base pulse
  // ***************************************************************
  always_comb begin
    half       = (div_reg == divider);
    div_next   = half ? 8'h00 : div_reg + 8'h01;
    phase_next = half ? ~phase_reg : phase_reg;
    tick_next  = half & phase_reg;
    run_next   = run_reg;
    // start and stop only at a period boundary
    if (half && phase_reg) begin
      run_next = run_req; // R16 R18
    end
    sck_next = run_next ? phase_next : idle_level; // R16 R18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg   <= 8'h00;
      phase_reg <= 1'b0;
      run_reg   <= 1'b0;
      tick_reg  <= 1'b0;
      sck_reg   <= 1'b0;
    end else begin
      div_reg   <= div_next;
      phase_reg <= phase_next;
      run_reg   <= run_next;
      tick_reg  <= tick_next;
      sck_reg   <= sck_next;
    end
  end

  assign base_tick = tick_reg;
  assign sck_level = sck_reg;

endmodule

// file: scc_top.sv
// smart card serial interface: apb registers, frame engine, card clock
// Behaviour
// [R01] bit timing runs on a base clock at 372 times the bit rate
// [R02] receiver aligns bit timing to the start bit falling edge
// [R03] each received bit is taken at the 186th base pulse of its bit
// [R04] a character frame is ten bit periods long
// [R05] bad received parity sets the parity error flag, error request if enabled
// [R06] software clears the parity error flag before the next parity bit
// [R07] a frame with a parity error leaves receive full unset
// [R08] good parity sets receive full, receive request if enabled
// [R09] after a good frame the data pin stays released in the error slot
// [R10] a returned error signal sets the error signal flag and error request; the code raises the request only with CTRL_RIE_BIT set
// [R11] software clears the error signal flag before the next parity bit
// [R12] a frame that drew an error signal does not set transmit end
// [R13] without a returned error signal the error signal flag stays unset
// [R14] without an error signal transmit end sets, transmit request if enabled
// [R15] software parks the clock pin and clears modes before standby
// [R16] clearing clock output finishes the current period, then holds idle level; the pin holds it one cycle, then follows PORT_DIR_BIT and PORT_DAT_BIT
// [R17] software matches clock select to the pin level when leaving standby
// [R18] restarted card clock has its normal duty cycle from the first period
// [R19] after reset the clock pin is an undriven input
// [R20] software sets level and modes before enabling clock output
// [R21] on an error signal the same character is resent, transmit end kept low
// [R22] a receive parity error drives the line low in the error slot
`timescale 1ns/100ps
module scc_top import scc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        data_i,
  output logic             data_o,
  output logic             data_oe,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  output logic             error_interrupt,
  output logic             receive_interrupt,
  output logic             transmit_interrupt
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [7:0]  serial_mode_reg,    serial_mode_next;
  logic [7:0]  bitrate_reg,        bitrate_next;
  logic [7:0]  serial_control_reg, serial_control_next;
  logic [7:0]  card_mode_reg,      card_mode_next;
  logic [7:0]  serial_port_reg,    serial_port_next;
  logic [7:0]  tdata_reg,          tdata_next;
  logic [7:0]  rdata_reg,          rdata_next;
  scc_flags_t  flags_reg,          flags_next;
  logic [31:0] prdata_reg,         prdata_next;
  logic        pready_reg,         pready_next;
  logic        pslverr_reg,        pslverr_next;
  scc_state_t  state_reg,          state_next;
  logic [8:0]  cnt_reg,            cnt_next;
  logic [3:0]  bit_reg,            bit_next;
  logic [9:0]  shift_reg,          shift_next;
  logic        pend_reg,           pend_next;
  logic        err_reg,            err_next;
  logic        rxprev_reg,         rxprev_next;
  scc_pin_t    dpin_reg,           dpin_next;
  scc_pin_t    cpin_reg,           cpin_next;
  logic [2:0]  irq_reg,            irq_next;
  logic        sckrun_reg,         sckrun_next;
  logic        runq_reg,           runq_next;
  logic [1:0]  pins_sync;
  logic        line;
  logic        sck_pin;
  logic        base_tick;
  logic        sck_level;
  logic        wr_en;
  logic        rd_en;
  logic        smif;
  logic        sample;
  logic        bit_end;
  scc_flags_t  set_f;
  scc_flags_t  clr_f;

  // ***************************************************************
  // pin synchronisers and clock generator
  // ***************************************************************
  scc_sync #(.WIDTH(2)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sck_i, data_i}),
    .sync_out (pins_sync)
  );

  assign line    = pins_sync[0];
  assign sck_pin = pins_sync[1];
  assign smif    = card_mode_reg[CARD_SMIF_BIT];

  scc_clkgen u_clkgen (
    .pclk       (pclk),
    .presetn    (presetn),
    .divider    (bitrate_reg),
    .run_req    (serial_control_reg[CTRL_CLOCK_OUTPUT_ENABLE_BIT] & smif),
    .idle_level (serial_control_reg[CTRL_CLOCK_SOURCE_SELECT_BIT]),
    .base_tick  (base_tick),
    .sck_level  (sck_level)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFF_PORT);
  endfunction

  // ***************************************************************
  // apb slave and registers
  // ***************************************************************
  always_comb begin
    wr_en = psel & penable & pready_reg & pwrite & mapped(paddr);
    rd_en = psel & ~penable;
    serial_mode_next    = serial_mode_reg;
    bitrate_next        = bitrate_reg;
    serial_control_next = serial_control_reg;
    card_mode_next      = card_mode_reg;
    serial_port_next    = serial_port_reg;
    tdata_next          = tdata_reg;
    clr_f               = '0;
    pready_next  = psel & ~penable;
    pslverr_next = psel & ~penable & ~mapped(paddr);
    prdata_next  = prdata_reg;
    if (wr_en) begin
      unique case (paddr)
        OFF_MODE:    serial_mode_next    = pwdata[7:0];
        OFF_BITRATE: bitrate_next        = pwdata[7:0];
        OFF_CTRL:    serial_control_next = pwdata[7:0];
        OFF_CARD:    card_mode_next      = pwdata[7:0];
        OFF_PORT:    serial_port_next    = pwdata[7:0];
        OFF_TDATA:   tdata_next          = pwdata[7:0];
        OFF_STATUS: begin
          // a written zero clears the flag
          clr_f.receive_full_flag = ~pwdata[STAT_RECEIVE_FULL_FLAG_BIT];
          clr_f.ers  = ~pwdata[STAT_ERS_BIT]; // R11
          clr_f.parity_error_flag  = ~pwdata[STAT_PER_BIT]; // R06
          clr_f.transmit_end_flag = ~pwdata[STAT_TRANSMIT_END_FLAG_BIT];
        end
        default: ;
      endcase
    end
    if (wr_en && paddr == OFF_TDATA) begin
      clr_f.transmit_end_flag = 1'b1;
    end
    if (rd_en) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        OFF_MODE:    prdata_next[7:0] = serial_mode_reg;
        OFF_BITRATE: prdata_next[7:0] = bitrate_reg;
        OFF_CTRL:    prdata_next[7:0] = serial_control_reg;
        OFF_CARD:    prdata_next[7:0] = card_mode_reg;
        OFF_TDATA:   prdata_next[7:0] = tdata_reg;
        OFF_RDATA:   prdata_next[7:0] = rdata_reg;
        OFF_STATUS: begin
          prdata_next[STAT_RECEIVE_FULL_FLAG_BIT] = flags_reg.receive_full_flag;
          prdata_next[STAT_ERS_BIT]  = flags_reg.ers;
          prdata_next[STAT_PER_BIT]  = flags_reg.parity_error_flag;
          prdata_next[STAT_TRANSMIT_END_FLAG_BIT] = flags_reg.transmit_end_flag;
        end
        OFF_PORT: begin
          prdata_next[7:0]            = serial_port_reg;
          prdata_next[PORT_SCKIN_BIT] = sck_pin;
          prdata_next[PORT_RXIN_BIT]  = line;
        end
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // frame engine
  // ***************************************************************
  always_comb begin
    sample      = base_tick && (cnt_reg == CNT_SAMPLE); // R03
    bit_end     = base_tick && (cnt_reg == CNT_LAST); // R01
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    bit_next    = bit_reg;
    shift_next  = shift_reg;
    err_next    = err_reg;
    rdata_next  = rdata_reg;
    rxprev_next = line;
    set_f       = '0;
    pend_next   = pend_reg;
    if (wr_en && paddr == OFF_TDATA) begin
      pend_next = 1'b1;
    end
    if (base_tick) begin
      cnt_next = bit_end ? 9'h000 : cnt_reg + 9'h001;
    end
    if (bit_end) begin
      bit_next = bit_reg + 4'h1;
    end
    unique case (state_reg)
      ST_IDLE: begin
        cnt_next = 9'h000;
        bit_next = 4'h0;
        err_next = 1'b0;
        if (smif && serial_control_reg[CTRL_TE_BIT] && pend_reg &&
            base_tick) begin
          shift_next = {^tdata_reg ^ serial_mode_reg[MODE_ODD_BIT],
                        tdata_reg, 1'b0};
          state_next = ST_TX_FRAME;
        end else if (smif && serial_control_reg[CTRL_RE_BIT] &&
                     rxprev_reg && !line) begin
          state_next = ST_RX_FRAME; // R02
        end
      end
      ST_RX_FRAME: begin
        if (sample) begin
          shift_next = {line, shift_reg[9:1]};
          if (bit_reg == 4'h0 && line) begin
            state_next = ST_IDLE;
          end
          if (bit_reg == BIT_PARITY) begin
            rdata_next = shift_reg[9:2];
            if (^shift_reg[9:2] ^ line ^ serial_mode_reg[MODE_ODD_BIT]) begin
              err_next  = 1'b1;
              set_f.parity_error_flag = 1'b1; // R05
            end else begin
              set_f.receive_full_flag = 1'b1; // R07 R08
            end
          end
        end
        if (bit_end && bit_reg == BIT_PARITY) begin
          state_next = ST_SLOT; // R04
        end
      end
      ST_TX_FRAME: begin
        if (bit_end) begin
          shift_next = {1'b1, shift_reg[9:1]};
          if (bit_reg == BIT_PARITY) begin
            state_next = ST_SLOT; // R04
          end
        end
      end
      ST_SLOT: begin
        if (sample && bit_reg == BIT_SLOT_B &&
            serial_control_reg[CTRL_TE_BIT] && !line) begin
          err_next  = 1'b1;
          set_f.ers = 1'b1; // R10 R13
        end
        if (bit_end && bit_reg == BIT_SLOT_B) begin
          state_next = ST_GUARD;
        end
      end
      ST_GUARD: begin
        if (bit_end) begin
          state_next = ST_IDLE;
          if (serial_control_reg[CTRL_TE_BIT] && !err_reg) begin
            pend_next  = 1'b0;
            set_f.transmit_end_flag = 1'b1; // R14
          end
          // pending kept on error: same character resent, no transmit_end_flag R12 R21
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!smif) begin
      state_next = ST_IDLE;
    end
    // set wins over a clear in the same cycle
    flags_next.receive_full_flag = set_f.receive_full_flag | (flags_reg.receive_full_flag & ~clr_f.receive_full_flag);
    flags_next.ers  = set_f.ers  | (flags_reg.ers  & ~clr_f.ers);
    flags_next.parity_error_flag  = set_f.parity_error_flag  | (flags_reg.parity_error_flag  & ~clr_f.parity_error_flag);
    flags_next.transmit_end_flag = set_f.transmit_end_flag | (flags_reg.transmit_end_flag & ~clr_f.transmit_end_flag);
  end

  // ***************************************************************
  // pin drivers and requests
  // ***************************************************************
  always_comb begin
    dpin_next = '{o: 1'b1, oe: 1'b0}; // R09
    if (state_reg == ST_TX_FRAME) begin
      dpin_next = '{o: shift_reg[0], oe: 1'b1};
    end else if (state_reg == ST_SLOT && err_reg &&
                 serial_control_reg[CTRL_RE_BIT] &&
                 ((bit_reg == BIT_SLOT_A && cnt_reg >= CNT_SAMPLE) ||
                  (bit_reg == BIT_SLOT_B && cnt_reg < CNT_SAMPLE))) begin
      dpin_next = '{o: 1'b0, oe: 1'b1}; // R22
    end
    // keep the card clock until the generator reaches its boundary
    runq_next   = smif & serial_control_reg[CTRL_CLOCK_OUTPUT_ENABLE_BIT];
    sckrun_next = sckrun_reg;
    if (runq_next) begin
      sckrun_next = 1'b1;
    end else if (base_tick && !runq_reg) begin
      sckrun_next = 1'b0; // R16
    end
    if (sckrun_reg) begin
      cpin_next = '{o: sck_level, oe: 1'b1}; // R16 R18
    end else if (serial_port_reg[PORT_DIR_BIT]) begin
      cpin_next = '{o: serial_port_reg[PORT_DAT_BIT], oe: 1'b1};
    end else begin
      cpin_next = '{o: 1'b0, oe: 1'b0}; // R19
    end
    irq_next[0] = serial_control_reg[CTRL_RIE_BIT] &
                  (flags_reg.parity_error_flag | flags_reg.ers); // R05 R10
    irq_next[1] = serial_control_reg[CTRL_RIE_BIT] & flags_reg.receive_full_flag; // R08
    irq_next[2] = serial_control_reg[CTRL_TIE_BIT] & flags_reg.transmit_end_flag; // R14
  end

  // ***************************************************************
  // state registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_reg    <= RST_MODE;
      bitrate_reg        <= RST_BITRATE;
      serial_control_reg <= RST_CTRL;
      card_mode_reg      <= RST_CARD;
      serial_port_reg    <= RST_PORT;
      tdata_reg          <= 8'h00;
      rdata_reg          <= 8'h00;
      flags_reg          <= '{receive_full_flag: 1'b0, ers: 1'b0, parity_error_flag: 1'b0, transmit_end_flag: 1'b1};
      prdata_reg         <= 32'h0000_0000;
      pready_reg         <= 1'b0;
      pslverr_reg        <= 1'b0;
      state_reg          <= ST_IDLE;
      cnt_reg            <= 9'h000;
      bit_reg            <= 4'h0;
      shift_reg          <= 10'h3FF;
      pend_reg           <= 1'b0;
      err_reg            <= 1'b0;
      rxprev_reg         <= 1'b1;
      dpin_reg           <= '{o: 1'b1, oe: 1'b0};
      cpin_reg           <= '{o: 1'b0, oe: 1'b0};
      irq_reg            <= 3'h0;
      sckrun_reg         <= 1'b0;
      runq_reg           <= 1'b0;
    end else begin
      serial_mode_reg    <= serial_mode_next;
      bitrate_reg        <= bitrate_next;
      serial_control_reg <= serial_control_next;
      card_mode_reg      <= card_mode_next;
      serial_port_reg    <= serial_port_next;
      tdata_reg          <= tdata_next;
      rdata_reg          <= rdata_next;
      flags_reg          <= flags_next;
      prdata_reg         <= prdata_next;
      pready_reg         <= pready_next;
      pslverr_reg        <= pslverr_next;
      state_reg          <= state_next;
      cnt_reg            <= cnt_next;
      bit_reg            <= bit_next;
      shift_reg          <= shift_next;
      pend_reg           <= pend_next;
      err_reg            <= err_next;
      rxprev_reg         <= rxprev_next;
      dpin_reg           <= dpin_next;
      cpin_reg           <= cpin_next;
      irq_reg            <= irq_next;
      sckrun_reg         <= sckrun_next;
      runq_reg           <= runq_next;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign data_o             = dpin_reg.o;
  assign data_oe            = dpin_reg.oe;
  assign sck_o              = cpin_reg.o;
  assign sck_oe             = cpin_reg.oe;
  assign error_interrupt    = irq_reg[0];
  assign receive_interrupt  = irq_reg[1];
  assign transmit_interrupt = irq_reg[2];

endmodule

// file: scc_top_assertions.sv
// port checks for the smart card serial interface
`timescale 1ns/100ps
module scc_top_assertions #(
  parameter int BIT_CYC = 744
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       data_o,
  input wire logic       data_oe,
  input wire logic       sck_oe,
  input wire logic       error_interrupt,
  input wire logic       receive_interrupt,
  input wire logic       transmit_interrupt
);
  // ****************
  // helper counters
  // ****************
  logic        wr_seen_reg;
  logic [15:0] on_reg;
  logic [15:0] off_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_reg <= 1'b0;
      on_reg      <= 16'h0;
      off_reg     <= 16'hFFFF;
    end else begin
      wr_seen_reg <= wr_seen_reg | (psel & penable & pwrite & pready);
      on_reg      <= data_oe ? on_reg + 16'h1 : 16'h0;
      off_reg     <= data_oe ? 16'h0 : off_reg + 16'(off_reg != 16'hFFFF);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (psel && !penable &&
    (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("no pslverr on unmapped address");
  a_clk_pin_input: assert property (!wr_seen_reg |-> !sck_oe)
    else $error("clock pin driven before setup");
  a_drive_span: assert property ($fell(data_oe) |->
    on_reg == 16'(10 * BIT_CYC) || on_reg == 16'(BIT_CYC))
    else $error("data drive span wrong");
  a_drive_low: assert property ($rose(data_oe) |->
    (data_oe && !data_o) [*8])
    else $error("drive does not start low");
  a_no_full_err: assert property ($rose(error_interrupt) |->
    !$rose(receive_interrupt))
    else $error("receive full with error");
  a_transmit_end_flag_guard: assert property ($rose(transmit_interrupt) |->
    off_reg >= 16'(3 * BIT_CYC - 4))
    else $error("transmit end before guard");
endmodule
bind scc_top scc_top_assertions scc_top_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .data_o(data_o), .data_oe(data_oe), .sck_oe(sck_oe),
  .error_interrupt(error_interrupt), .receive_interrupt(receive_interrupt),
  .transmit_interrupt(transmit_interrupt));

// file: scc_card_model.sv
// card model on the shared data line
`timescale 1ns/100ps
module scc_card_model (
  input  wire logic pclk,
  input  wire logic line,
  output logic      card_low
);
  localparam int BIT = 744;
  initial card_low = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // send one character, then look for the error signal
  task automatic send(input logic [7:0] d, input logic bad,
                      output logic nack);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      card_low <= ~f[i];
      tick(BIT);
    end
    card_low <= 1'b0;
    tick(BIT);
    nack = ~line;
    tick(2 * BIT);
  endtask
  // take one character, answer with an error signal on request
  task automatic recv(input logic nack, output logic [7:0] d);
    logic [9:0] f;
    int         n;
    n = 0;
    while (line && n < 40000) begin
      tick(1);
      n++;
    end
    tick(BIT / 2);
    for (int i = 0; i < 10; i++) begin
      f[i] = line;
      tick(BIT);
    end
    d = f[8:1];
    card_low <= nack;
    tick(BIT + BIT / 4);
    card_low <= 1'b0;
    tick(BIT / 2);
  endtask
endmodule

// file: scc_top_test.sv
// self-checking bench for the smart card serial interface
`timescale 1ns/100ps
module scc_top_test;
  import scc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ext_clk;
  logic [7:0]  paddr, d, got;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, erv, data_o, data_oe, sck_o, sck_oe;
  logic        error_interrupt, receive_interrupt, transmit_interrupt;
  logic        line, sck_pin, card_low, nack, s0;
  int          fails = 0;
  int          num_checks = 0;
  int          seed = 32'h1B1DAEC4;
  int          k;
  assign line = ~((data_oe & ~data_o) | card_low);
  assign sck_pin = sck_oe ? sck_o : ext_clk;
  scc_top scc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_i(line),
    .data_o(data_o), .data_oe(data_oe), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe(sck_oe), .error_interrupt(error_interrupt),
    .receive_interrupt(receive_interrupt),
    .transmit_interrupt(transmit_interrupt));
  scc_card_model scc_card_model_inst (.pclk(pclk), .line(line),
    .card_low(card_low));
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    ext_clk = 1'b0;
    forever #62.5 ext_clk = ~ext_clk;
  end
  initial begin
    tick(90000);
    fails++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    tick(12);
    presetn <= 1'b1;
    rd("status", OFF_STATUS, 32'h04);
    rd("bitrate", OFF_BITRATE, 32'hFF);
    rd("unmapped", 8'h20, 32'h0);
    chk("slverr", erv, 32'h1);
    chk("sck_oe", sck_oe, 32'h0);
    wr(OFF_CTRL, 8'h02);
    wr(OFF_BITRATE, 8'h00);
    wr(OFF_CARD, 8'h01);
    wr(OFF_CTRL, 8'hE3);
    tick(8);
    chk("sck_oe", sck_oe, 32'h1);
    $display("test reset done");
    for (k = 0; k < 2; k++) begin
      d = k ? $random(seed) : 8'hFF;
      wr(OFF_TDATA, d);
      scc_card_model_inst.recv(k[0], got);
      if (k == 1) begin
        rd("status", OFF_STATUS, 32'h10);
        chk("txi", transmit_interrupt, 32'h0);
        chk("eri", error_interrupt, 32'h1);
        wr(OFF_STATUS, 8'h04);
        scc_card_model_inst.recv(1'b0, got);
      end
      chk("txd", got, d);
      tick(744);
      rd("status", OFF_STATUS, 32'h04);
      chk("txi", transmit_interrupt, 32'h1);
    end
    $display("test transmit done");
    wr(OFF_CTRL, 8'h51);
    for (k = 0; k < 2; k++) begin
      d = k ? 8'h00 : $random(seed);
      scc_card_model_inst.send(d, k[0], nack);
      chk("nack", nack, k);
      rd("status", OFF_STATUS, k ? 32'h0C : 32'h44);
      chk("rxi", receive_interrupt, k == 0);
      chk("eri", error_interrupt, k);
      rd("rdata", OFF_RDATA, d);
      wr(OFF_STATUS, 8'h04);
    end
    $display("test receive done");
    wr(OFF_PORT, 8'h0C);
    wr(OFF_CTRL, 8'h03);
    wr(OFF_CTRL, 8'h02);
    tick(4);
    repeat (4) begin
      tick(1);
      chk("sck_hold", sck_o, 32'h1);
    end
    wr(OFF_MODE, 8'h00);
    wr(OFF_CARD, 8'h00);
    wr(OFF_CTRL, 8'h02);
    wr(OFF_CARD, 8'h01);
    wr(OFF_CTRL, 8'h03);
    tick(8);
    s0 = sck_o;
    tick(1);
    chk("sck_run", sck_o, {31'h0, ~s0});
    $display("test clock done");
    tally_and_finish();
  end
endmodule
